// [src/timer_counter_trigger_control.v]
`timescale 1ns/100ps
// Overview of operation
// - Counter actions are OR of both signals
// - No actions unless trigger enable status set
// - Bits 15:13 qualify edges or levels
// - Signal 0 channel-trigger/watchdog sources use rising
// - Signal 1 qualifier only for pins, comparators, outputs
// - Signal 1 source code in bits 11:8
// - Bit 7 enables capture trigger
// - Bit 2 enables stop
// - Bit 0 enables start
// - Bit 3 clears on stop condition
// - Bit 1 clears on start condition
// - Clear condition from bit 1 or bit 3 applies pending register update; one-shot restart clear does not
// - No stop clear when already stopped with R/R or F/R codes or channel triggers
// - No start clear when already running with R/R or F/R codes or channel triggers
// - One-shot level mode restarts from zero
`include "trig_ctl_defs.vh"
module timer_counter_trigger_control #(
  parameter [3:0] WATCHDOG_SRC_CODE = 4'hB
) (
  input  wire        clock_i,
  input  wire        srst_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire [15:0] sources0_i,
  input  wire [15:0] sources1_i,
  input  wire        running_i,
  input  wire        one_shot_i,
  input  wire        one_shot_end_i,
  input  wire        update_pending_i,
  output reg         start_o,
  output reg         stop_o,
  output reg         clear_o,
  output reg         capture_o,
  output reg         update_apply_o,
  output reg         trig_en_o
);
  reg  [15:0] sel0_q;
  reg  [15:0] sel1_q;
  reg         trig_en_q;
  wire [1:0]  src;
  wire [1:0]  st;
  wire [1:0]  sp;
  wire [1:0]  lvl;
  wire [1:0]  rise;
  wire [1:0]  force_rise;
  wire [1:0]  chan_trg;
  wire [15:0] cfg [0:1];
  reg         start_d;
  reg         stop_d;
  reg         clear_d;
  reg         cap_d;
  reg         upd_d;
  reg         st_clr;
  reg         sp_clr;
  reg         hold_zero;
  integer     i;

  assign cfg[0] = sel0_q;
  assign cfg[1] = sel1_q;
  // Channel triggers are edge-only for both signals
  assign chan_trg[0] = (sel0_q[`TRG_SRC_HI:`TRG_SRC_LO] >= `SRC0_CHAN_TRG_MIN);
  assign chan_trg[1] = (sel1_q[`TRG_SRC_HI:`TRG_SRC_LO] >= `SRC1_CHAN_TRG_LO);
  assign force_rise[0] = chan_trg[0] |
                         (sel0_q[`TRG_SRC_HI:`TRG_SRC_LO] == WATCHDOG_SRC_CODE);
  assign force_rise[1] = chan_trg[1];

  trig_source_mux u_mux0 (
    .sources_i (sources0_i),
    .sel_i     (sel0_q[`TRG_SRC_HI:`TRG_SRC_LO]),
    .src_o     (src[0])
  );
  trig_source_mux u_mux1 (
    .sources_i (sources1_i),
    .sel_i     (sel1_q[`TRG_SRC_HI:`TRG_SRC_LO]),
    .src_o     (src[1])
  );
  trig_qualifier u_qual0 (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .src_i        (src[0]),
    .qual_i       (sel0_q[`TRG_QUAL_HI:`TRG_QUAL_LO]),
    .force_rise_i (force_rise[0]),
    .start_o      (st[0]),
    .stop_o       (sp[0]),
    .level_mode_o (lvl[0]),
    .rise_o       (rise[0])
  );
  trig_qualifier u_qual1 (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .src_i        (src[1]),
    .qual_i       (sel1_q[`TRG_QUAL_HI:`TRG_QUAL_LO]),
    .force_rise_i (force_rise[1]),
    .start_o      (st[1]),
    .stop_o       (sp[1]),
    .level_mode_o (lvl[1]),
    .rise_o       (rise[1])
  );

  // Register writes; edits while enabled may fire a spurious event, software's duty
  always @(posedge clock_i) begin
    if (srst_i) begin
      sel0_q    <= `TRG_REG_RESET;
      sel1_q    <= `TRG_REG_RESET;
      trig_en_q <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `TRG_SEL0_OFFSET) begin
        sel0_q <= wdata_i & `TRG_REG_MASK;
      end
      if (addr_i == `TRG_SEL1_OFFSET) begin
        sel1_q <= wdata_i & `TRG_REG_MASK;
      end
      if (addr_i == `TRG_ENABLE_OFFSET) begin
        trig_en_q <= wdata_i[0];
      end
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `TRG_SEL0_OFFSET:   rdata_o <= sel0_q;
        `TRG_SEL1_OFFSET:   rdata_o <= sel1_q;
        `TRG_ENABLE_OFFSET: rdata_o <= {15'h0000, trig_en_q};
        `TRG_STATUS_OFFSET: rdata_o <= {13'h0000, update_pending_i, one_shot_i, running_i};
        default:            rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // Per-signal actions, OR-combined across both signals
  always @* begin
    start_d   = 1'b0;
    stop_d    = 1'b0;
    clear_d   = 1'b0;
    cap_d     = 1'b0;
    upd_d     = 1'b0;
    hold_zero = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      st_clr = 1'b0;
      sp_clr = 1'b0;
      if (trig_en_q) begin
        if (cfg[i][`TRG_START_EN_BIT] & st[i] & ~running_i) begin
          start_d = 1'b1;
        end
        if (cfg[i][`TRG_STOP_EN_BIT] & sp[i] & running_i) begin
          stop_d = 1'b1;
        end
        // Edge-type rising/rising or F/R codes and channel triggers skip redundant clears
        if (cfg[i][`TRG_START_CLR_BIT] & st[i]) begin
          st_clr = ~(running_i & (chan_trg[i] | (~lvl[i] &
                   ((cfg[i][15:13] == `QUAL_RR) | (cfg[i][15:13] == `QUAL_FF)))));
        end
        if (cfg[i][`TRG_STOP_CLR_BIT] & sp[i]) begin
          sp_clr = ~(~running_i & (chan_trg[i] | (~lvl[i] &
                   ((cfg[i][15:13] == `QUAL_RR) | (cfg[i][15:13] == `QUAL_FF)))));
        end
        if (st_clr | sp_clr) begin
          clear_d = 1'b1;
          upd_d   = update_pending_i;
        end
        if (cfg[i][`TRG_CAP_BIT] & rise[i]) begin
          cap_d = 1'b1;
        end
        // Level start still true at one-shot end: keep running from zero
        if (one_shot_i & one_shot_end_i & lvl[i] & st[i] & cfg[i][`TRG_START_EN_BIT]) begin
          hold_zero = 1'b1;
        end
      end
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      start_o        <= 1'b0;
      stop_o         <= 1'b0;
      clear_o        <= 1'b0;
      capture_o      <= 1'b0;
      update_apply_o <= 1'b0;
      trig_en_o      <= 1'b0;
    end else begin
      start_o        <= start_d | hold_zero;
      stop_o         <= stop_d & ~hold_zero;
      clear_o        <= clear_d | hold_zero;
      capture_o      <= cap_d;
      update_apply_o <= upd_d;
      trig_en_o      <= trig_en_q;
    end
  end
endmodule // timer_counter_trigger_control

// [pkg/trig_ctl_defs.vh]
`ifndef TRIG_CTL_DEFS_VH
`define TRIG_CTL_DEFS_VH
`define TRG_SEL1_OFFSET   16'hF3A0
`define TRG_SEL0_OFFSET   16'hF414
`define TRG_ENABLE_OFFSET 16'hF420
`define TRG_STATUS_OFFSET 16'hF422
`define TRG_REG_RESET     16'h0000
`define TRG_REG_MASK      16'hEF8F
`define TRG_QUAL_HI       15
`define TRG_QUAL_LO       13
`define TRG_SRC_HI        11
`define TRG_SRC_LO        8
`define TRG_CAP_BIT       7
`define TRG_STOP_CLR_BIT  3
`define TRG_STOP_EN_BIT   2
`define TRG_START_CLR_BIT 1
`define TRG_START_EN_BIT  0
`define QUAL_RR           3'h0
`define QUAL_FF           3'h3
`define SRC1_CHAN_TRG_LO  4'hB
`define SRC1_CHAN_TRG_HI  4'hF
`define SRC0_CHAN_TRG_MIN 4'hC
`endif

// [src/trig_qualifier.v]
`timescale 1ns/100ps
// One control signal: edge or level start and stop conditions
module trig_qualifier (
  input  wire       clock_i,
  input  wire       srst_i,
  input  wire       src_i,
  input  wire [2:0] qual_i,
  input  wire       force_rise_i,
  output wire       start_o,
  output wire       stop_o,
  output wire       level_mode_o,
  output wire       rise_o
);
  reg        prev_q;
  wire       rise;
  wire       fall;
  wire [2:0] q;
  always @(posedge clock_i) begin
    if (srst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= src_i;
    end
  end
  assign rise = src_i & ~prev_q;
  assign fall = ~src_i & prev_q;
  assign q = force_rise_i ? 3'h0 : qual_i;
  assign rise_o = rise;
  assign level_mode_o = q[2];
  // Codes: 000 R/R, 001 F/F, 010 R/F, 011 F/R, 1X0 H/L, 1X1 L/H
  assign start_o = q[2] ? (q[0] ? ~src_i : src_i) : (q[0] ? fall : rise);
  assign stop_o  = q[2] ? (q[0] ? src_i : ~src_i) : (q[1] ? ~q[0] ? fall : rise
                                                         : (q[0] ? fall : rise));
endmodule // trig_qualifier

// [src/trig_source_mux.v]
`timescale 1ns/100ps
// Picks one of sixteen trigger sources by a 4-bit code
module trig_source_mux (
  input  wire [15:0] sources_i,
  input  wire [3:0]  sel_i,
  output wire        src_o
);
  assign src_o = sources_i[sel_i];
endmodule // trig_source_mux

// [test/trig_src_model.sv]
`timescale 1ns/100ps
// Far-side trigger sources: one request gives one pulse on the chosen line
module trig_src_model (
  input  wire        clock_i,
  input  wire        fire_i,
  input  wire [3:0]  code_i,
  output logic [15:0] src_o
);
  logic [1:0] hold_q = 2'h0;
  always_ff @(posedge clock_i) begin
    if (fire_i) hold_q <= 2'h2;
    else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
  end
  // Unselected lines idle low, like pins with pull-downs
  assign src_o = (hold_q != 2'h0) ? (16'h0001 << code_i) : 16'h0000;
endmodule // trig_src_model

// [test/trig_ctl_monitor.sv]
`timescale 1ns/100ps
module trig_ctl_monitor (
  input wire        clock_i,
  input wire        srst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [15:0] rdata_o,
  input wire        one_shot_i,
  input wire        update_pending_i,
  input wire        start_o,
  input wire        stop_o,
  input wire        clear_o,
  input wire        capture_o,
  input wire        update_apply_o,
  input wire        trig_en_o
);
  logic [15:0] c0_q;
  logic [15:0] c1_q;
  wire         act = start_o | stop_o | clear_o | capture_o | update_apply_o;
  // Shadows hold only because selects are edited with triggers off
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      c0_q <= 16'h0000;
      c1_q <= 16'h0000;
    end else if (wr_i) begin
      if (addr_i == 16'hF414) c0_q <= wdata_i;
      if (addr_i == 16'hF3A0) c1_q <= wdata_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  off_no_act_a: assert property (!trig_en_o && !$past(trig_en_o) |-> !act)
    else $error("action while disabled");
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside slot");
  rd_back_a: assert property (
    rd_i && addr_i == 16'hF3A0 |=> rdata_o == ($past(c1_q) & 16'hEF8F))
    else $error("select 1 readback");
  start_gate_a: assert property (start_o |-> c0_q[0] | c1_q[0])
    else $error("start without enable");
  stop_gate_a: assert property (stop_o |-> c0_q[2] | c1_q[2])
    else $error("stop without enable");
  cap_gate_a: assert property (capture_o |-> c0_q[7] | c1_q[7])
    else $error("capture without enable");
  clr_gate_a: assert property (
    clear_o |-> c0_q[1] | c0_q[3] | c1_q[1] | c1_q[3] | one_shot_i)
    else $error("clear without enable");
  upd_gate_a: assert property (update_apply_o |-> clear_o && $past(update_pending_i))
    else $error("update without clear");
  cover property (start_o);
  cover property (stop_o);
  cover property (clear_o && update_apply_o);
endmodule // trig_ctl_monitor
bind timer_counter_trigger_control trig_ctl_monitor mon (.*);

// [test/tb_timer_counter_trigger_control.sv]
`timescale 1ns/100ps
module tb_timer_counter_trigger_control;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        running_i = 1'b0;
  logic        pend = 1'b0;
  logic        fire = 1'b0;
  logic [3:0]  code = 4'h0;
  logic        oneshot = 1'b0;
  logic        oend = 1'b0;
  wire         ten;
  logic [15:0] src;
  logic [15:0] rdata;
  wire         st, sp, cl, cp, up;
  int          failures = 0;
  int          total_checks = 0;
  timer_counter_trigger_control dut (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o(rdata), .sources0_i(src), .sources1_i(src), .running_i, .one_shot_i(oneshot),
    .one_shot_end_i(oend), .update_pending_i(pend), .start_o(st), .stop_o(sp),
    .clear_o(cl), .capture_o(cp), .update_apply_o(up), .trig_en_o(ten));
  trig_src_model far (.clock_i, .fire_i(fire), .code_i(code), .src_o(src));
  initial forever #4 clock_i = ~clock_i;
  task automatic check(input string what, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 check("rdata", rdata, e);
  endtask
  // Mode is {enable, running, update pending}; counts are 2 bits each
  task automatic run(input logic [15:0] c0, input logic [15:0] c1, input logic [2:0] m,
                     input logic [3:0] cd, input logic [9:0] e);
    logic [9:0] n;
    n = 10'h000;
    wr(16'hF420, 16'h0000);
    wr(16'hF414, c0);
    wr(16'hF3A0, c1);
    wr(16'hF420, {15'h0000, m[2]});
    running_i <= m[1];
    pend <= m[0];
    code <= cd;
    @(posedge clock_i);
    fire <= 1'b1;
    @(posedge clock_i);
    fire <= 1'b0;
    repeat (6) begin
      @(posedge clock_i);
      #1 n = n + {1'b0, st, 1'b0, sp, 1'b0, cl, 1'b0, cp, 1'b0, up};
    end
    check("actions", {6'h00, n}, {6'h00, e});
    $display("test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(16'hF414, 16'h0000);
    rd(16'hF3A0, 16'h0000);
    rd(16'h1234, 16'h0000);
    wr(16'hF414, 16'hFFFF);
    rd(16'hF414, 16'hEF8F);
    wr(16'hF3A0, 16'hFFFF);
    rd(16'hF3A0, 16'hEF8F);
    run(16'h0001, 16'h0000, 3'h0, 4'h0, 10'h000);
    run(16'h0001, 16'h0000, 3'h4, 4'h0, 10'h100);
    run(16'h0000, 16'h0000, 3'h4, 4'h0, 10'h000);
    run(16'h0004, 16'h0000, 3'h6, 4'h0, 10'h040);
    run(16'h0008, 16'h0000, 3'h7, 4'h0, 10'h011);
    rd(16'hF422, 16'h0005);
    rd(16'hF420, 16'h0001);
    check("trig_en", {15'h0000, ten}, 16'h0001);
    run(16'h0008, 16'h0000, 3'h5, 4'h0, 10'h000);
    run(16'h0002, 16'h0000, 3'h5, 4'h0, 10'h011);
    run(16'h0002, 16'h0000, 3'h7, 4'h0, 10'h000);
    run(16'h0080, 16'h0000, 3'h4, 4'h0, 10'h004);
    run(16'h0000, 16'h0301, 3'h4, 4'h3, 10'h100);
    run(16'h0301, 16'h0301, 3'h4, 4'h3, 10'h100);
    run(16'h8001, 16'h0000, 3'h4, 4'h0, 10'h200);
    run(16'h2001, 16'h0000, 3'h4, 4'h0, 10'h100);
    run(16'h4001, 16'h0000, 3'h4, 4'h0, 10'h100);
    run(16'h6001, 16'h0000, 3'h4, 4'h0, 10'h100);
    oneshot <= 1'b1;
    oend <= 1'b1;
    run(16'h8001, 16'h0000, 3'h6, 4'h0, 10'h220);
    oneshot <= 1'b0;
    oend <= 1'b0;
    run(16'h8B01, 16'h0000, 3'h4, 4'hB, 10'h100);
    run(16'h0000, 16'h8C01, 3'h4, 4'hC, 10'h100);
    print_verdict();
  end
endmodule // tb_timer_counter_trigger_control
